// ---- inc/aassc_regs.svh ----
// Register offsets, field positions, reset values and codes for the step configuration bank.
// Assumes nothing; included by the package-using design file by bare name.
`ifndef AASSC_REGS_SVH
`define AASSC_REGS_SVH
// ****************************************************************
// Register offsets (byte addresses on the register port)
// ****************************************************************
`define AASSC_STEP11_OFFSET   8'hdb
`define AASSC_STEP12_OFFSET   8'hdc
// ****************************************************************
// Reset values
// ****************************************************************
`define AASSC_STEP11_RESET    16'h000b
`define AASSC_STEP12_RESET    16'h000c
// ****************************************************************
// Field positions
// ****************************************************************
`define AASSC_EN_BIT          15
`define AASSC_GAIN_HI         14
`define AASSC_GAIN_LO         13
`define AASSC_NEG_BIT         4
`define AASSC_POS_HI          3
`define AASSC_POS_LO          0
// Writable bits of a step register; bits 12:5 stay zero.
`define AASSC_WMASK           16'he01f
// First positive code that picks an internal source.
`define AASSC_POS_INTERNAL    4'h8
`endif

// ---- inc/aassc_pkg.sv ----
// Types shared by the step configuration bank.
// Assumes the register header is available on the include path.
package aassc_pkg;
    // Converter gain as applied to the multiplexed converter.
    typedef enum logic [1:0] {
        AASSC_GAIN_X1 = 2'h0,
        AASSC_GAIN_X2 = 2'h1,
        AASSC_GAIN_X4 = 2'h2
    } aassc_gain_t;
    // Negative input source.
    typedef enum logic [1:0] {
        AASSC_NEG_GROUND = 2'h0,
        AASSC_NEG_EXT7   = 2'h1,
        AASSC_NEG_AUTO   = 2'h2
    } aassc_neg_t;
endpackage : aassc_pkg

// ---- logic/aassc_step_cfg.sv ----
// Step 11 and step 12 configuration registers of the secondary multiplexed converter sequencer.
// Assumes a single-cycle register port and a sequencer that presents one step index at a time.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "aassc_regs.svh"
module aassc_step_cfg (
    input  wire logic                 clock,
    input  wire logic                 rstn,
    input  wire logic [7:0]           addr,
    input  wire logic [15:0]          wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [15:0]          rdata,
    input  wire logic                 step_req,
    input  wire logic [3:0]           step_idx,
    output logic                      step_valid_ff,
    output logic                      step_skip_ff,
    output aassc_pkg::aassc_gain_t    step_gain_ff,
    output aassc_pkg::aassc_neg_t     step_neg_ff,
    output logic      [3:0]           step_pos_ff
);
    import aassc_pkg::*;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [15:0] step11_ff;
    logic [15:0] step12_ff;
    logic [15:0] rdata_ff;
    wire         hit11 = (addr == `AASSC_STEP11_OFFSET);
    wire         hit12 = (addr == `AASSC_STEP12_OFFSET);
    // Reserved bits are masked off on write so they can never read back non-zero.
    wire  [15:0] wmasked = wdata & `AASSC_WMASK;

    // Register writes; unmapped addresses are ignored.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            step11_ff <= `AASSC_STEP11_RESET;
            step12_ff <= `AASSC_STEP12_RESET;
        end else if (wr) begin
            if (hit11) step11_ff <= wmasked;
            if (hit12) step12_ff <= wmasked;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Unmapped reads return zero.
    wire [15:0] nxt_rdata = hit11 ? step11_ff : (hit12 ? step12_ff : 16'h0000);

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) rdata_ff <= 16'h0000;
        else       rdata_ff <= rd ? nxt_rdata : 16'h0000;
    end
    assign rdata = rdata_ff;

    // ****************************************************************
    // Step decode toward the converter
    // ****************************************************************
    wire [15:0] sel      = (step_idx == 4'hc) ? step12_ff : step11_ff;
    wire        known    = (step_idx == 4'hb) || (step_idx == 4'hc);
    wire        sel_en   = sel[`AASSC_EN_BIT];
    wire [1:0]  sel_gc   = sel[`AASSC_GAIN_HI:`AASSC_GAIN_LO];
    wire [3:0]  sel_pos  = sel[`AASSC_POS_HI:`AASSC_POS_LO];
    wire        pos_int  = (sel_pos >= `AASSC_POS_INTERNAL);
    // Codes 10 and 11 share the largest gain.
    aassc_gain_t nxt_gain;
    assign nxt_gain = (sel_gc == 2'h0) ? AASSC_GAIN_X1 :
                      (sel_gc == 2'h1) ? AASSC_GAIN_X2 : AASSC_GAIN_X4;
    // Internal sources pick their own negative input, so bit 4 is ignored.
    aassc_neg_t nxt_neg;
    assign nxt_neg = pos_int ? AASSC_NEG_AUTO :
                     (sel[`AASSC_NEG_BIT] ? AASSC_NEG_EXT7 : AASSC_NEG_GROUND);
    wire nxt_valid = step_req && known && sel_en;
    wire nxt_skip  = step_req && !(known && sel_en);

    // Settings are latched only for an enabled step; skipped steps leave them alone.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            step_valid_ff <= 1'b0;
            step_skip_ff  <= 1'b0;
            step_gain_ff  <= AASSC_GAIN_X1;
            step_neg_ff   <= AASSC_NEG_GROUND;
            step_pos_ff   <= 4'h0;
        end else begin
            step_valid_ff <= nxt_valid;
            step_skip_ff  <= nxt_skip;
            if (nxt_valid) begin
                step_gain_ff <= nxt_gain;
                step_neg_ff  <= nxt_neg;
                step_pos_ff  <= sel_pos;
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_reserved_zero;
        @(posedge clock) disable iff (!rstn) (step11_ff[12:5] == 8'h00) && (step12_ff[12:5] == 8'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits not zero.");
    property p_read_reserved;
        @(posedge clock) disable iff (!rstn) rd |=> (rdata[12:5] == 8'h00);
    endproperty
    a_read_reserved: assert property (p_read_reserved) else $error("Reserved read non-zero.");
    property p_step12_read;
        @(posedge clock) disable iff (!rstn)
            (rd && addr == `AASSC_STEP12_OFFSET) |=> (rdata == $past(step12_ff));
    endproperty
    a_step12_read: assert property (p_step12_read) else $error("Step 12 read mismatch.");
    property p_write_en;
        @(posedge clock) disable iff (!rstn)
            (wr && addr == `AASSC_STEP11_OFFSET) |=> (step11_ff[15] == $past(wdata[15]));
    endproperty
    a_write_en: assert property (p_write_en) else $error("Enable bit not written.");
    property p_gain_map;
        @(posedge clock) disable iff (!rstn)
            nxt_valid |=> (step_gain_ff == (($past(sel_gc) == 2'h0) ? AASSC_GAIN_X1 :
                          ($past(sel_gc) == 2'h1) ? AASSC_GAIN_X2 : AASSC_GAIN_X4));
    endproperty
    a_gain_map: assert property (p_gain_map) else $error("Gain mapping wrong.");
    property p_neg_ext;
        @(posedge clock) disable iff (!rstn)
            (nxt_valid && sel_pos < 4'h8) |=> (step_neg_ff == ($past(sel[4]) ? AASSC_NEG_EXT7 : AASSC_NEG_GROUND));
    endproperty
    a_neg_ext: assert property (p_neg_ext) else $error("Negative select wrong.");
    property p_neg_auto;
        @(posedge clock) disable iff (!rstn)
            (nxt_valid && sel_pos >= 4'h8) |=> (step_neg_ff == AASSC_NEG_AUTO);
    endproperty
    a_neg_auto: assert property (p_neg_auto) else $error("Auto negative not taken.");
    property p_pos_route;
        @(posedge clock) disable iff (!rstn) nxt_valid |=> (step_pos_ff == $past(sel_pos));
    endproperty
    a_pos_route: assert property (p_pos_route) else $error("Positive select wrong.");
    property p_skip;
        @(posedge clock) disable iff (!rstn)
            (step_req && !sel_en) |=> (step_skip_ff && !step_valid_ff);
    endproperty
    a_skip: assert property (p_skip) else $error("Disabled step not skipped.");
    // Internal sources always carry the automatic negative input with them.
    property p_internal_hold;
        @(posedge clock) disable iff (!rstn)
            (step_valid_ff && step_pos_ff >= `AASSC_POS_INTERNAL) |-> (step_neg_ff == AASSC_NEG_AUTO);
    endproperty
    a_internal_hold: assert property (p_internal_hold) else $error("Internal code lost auto negative.");

    // ****************************************************************
    // Further register port checks
    // ****************************************************************
    // Step 11 reads back what was stored, so software can confirm its enable bit.
    property p_step11_read;
        @(posedge clock) disable iff (!rstn)
            (rd && addr == `AASSC_STEP11_OFFSET) |=> (rdata == $past(step11_ff));
    endproperty
    a_step11_read: assert property (p_step11_read) else $error("Step 11 read mismatch.");

    // A write to step 12 keeps every writable bit and drops the reserved ones.
    property p_write_step12;
        @(posedge clock) disable iff (!rstn)
            (wr && addr == `AASSC_STEP12_OFFSET) |=> (step12_ff == ($past(wdata) & `AASSC_WMASK));
    endproperty
    a_write_step12: assert property (p_write_step12) else $error("Step 12 write mismatch.");

    // ****************************************************************
    // Further step port checks
    // ****************************************************************
    // A valid pulse only ever follows a request whose enable bit was set.
    property p_valid_needs_enable;
        @(posedge clock) disable iff (!rstn) step_valid_ff |-> $past(sel_en);
    endproperty
    a_valid_needs_enable: assert property (p_valid_needs_enable) else $error("Valid without enable.");

    // Both upper gain codes give the largest gain.
    property p_gain_x4;
        @(posedge clock) disable iff (!rstn)
            (nxt_valid && sel_gc[1]) |=> (step_gain_ff == AASSC_GAIN_X4);
    endproperty
    a_gain_x4: assert property (p_gain_x4) else $error("Upper gain code not x4.");

    // An external positive input never carries the automatic negative selection.
    property p_external_pos;
        @(posedge clock) disable iff (!rstn)
            (step_valid_ff && step_pos_ff < `AASSC_POS_INTERNAL) |-> (step_neg_ff != AASSC_NEG_AUTO);
    endproperty
    a_external_pos: assert property (p_external_pos) else $error("External input got auto negative.");

    // The two answer pulses exclude each other.
    property p_valid_skip_excl;
        @(posedge clock) disable iff (!rstn) !(step_valid_ff && step_skip_ff);
    endproperty
    a_valid_skip_excl: assert property (p_valid_skip_excl) else $error("Valid and skip together.");

    // Every request gets exactly one answer pulse in the next cycle.
    property p_request_answered;
        @(posedge clock) disable iff (!rstn)
            step_req |=> (step_valid_ff ^ step_skip_ff);
    endproperty
    a_request_answered: assert property (p_request_answered) else $error("Request not answered.");

    // A skipped step or an idle cycle leaves the applied settings untouched.
    property p_settings_hold;
        @(posedge clock) disable iff (!rstn)
            !nxt_valid |=> ($stable(step_gain_ff) && $stable(step_neg_ff) && $stable(step_pos_ff));
    endproperty
    a_settings_hold: assert property (p_settings_hold) else $error("Settings moved without valid step.");

    // ****************************************************************
    // Cover points
    // ****************************************************************
    c_valid_step: cover property (@(posedge clock) disable iff (!rstn) step_valid_ff);
    c_skip_step:  cover property (@(posedge clock) disable iff (!rstn) step_skip_ff);
    c_auto_neg:   cover property (@(posedge clock) disable iff (!rstn) step_valid_ff && step_neg_ff == AASSC_NEG_AUTO);
    c_gain_x4:    cover property (@(posedge clock) disable iff (!rstn)
                                  step_valid_ff && step_gain_ff == AASSC_GAIN_X4);
    c_ext7_neg:   cover property (@(posedge clock) disable iff (!rstn)
                                  step_valid_ff && step_neg_ff == AASSC_NEG_EXT7);
endmodule : aassc_step_cfg

// ---- dv/aassc_step_cfg_tb.sv ----
// Testbench for the step configuration bank: register port and step port checks.
// Assumes the package is compiled first and that the design takes one-cycle strobes.
`timescale 1ns/100ps
module aassc_step_cfg_tb;
    import aassc_pkg::*;
    logic        clock, rstn, wr, rd, step_req;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, v;
    logic [3:0]  step_idx, step_pos_ff;
    logic        step_valid_ff, step_skip_ff;
    aassc_gain_t step_gain_ff, eg;
    aassc_neg_t  step_neg_ff, en;
    int          errors = 0, cmp_count = 0, cycles = 0, i;

    aassc_step_cfg aassc_step_cfg_i (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .step_req(step_req), .step_idx(step_idx), .step_valid_ff(step_valid_ff),
        .step_skip_ff(step_skip_ff), .step_gain_ff(step_gain_ff), .step_neg_ff(step_neg_ff),
        .step_pos_ff(step_pos_ff));

    // ****************************************************************
    // Clock, hang guard and shared tasks
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // The whole run needs well under a thousand cycles, so three thousand means a hang.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data are looked at only in the one cycle after the strobe, where they stand.
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_chk
    task automatic step_chk(input logic [3:0] idx, input logic ok, input aassc_gain_t g, input aassc_neg_t n,
                            input logic [3:0] p);
        @(posedge clock);
        step_req <= 1'b1;
        step_idx <= idx;
        @(posedge clock);
        step_req <= 1'b0;
        #1 chk({14'h0, step_valid_ff, step_skip_ff}, {14'h0, ok, ~ok});
        chk({8'h0, step_gain_ff, step_neg_ff, step_pos_ff}, {8'h0, g, n, p});
    endtask : step_chk

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        step_req = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        step_idx = 4'h0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        rd_chk(8'hdb, 16'h000b);
        rd_chk(8'hdc, 16'h000c);
        step_chk(4'hc, 1'b0, AASSC_GAIN_X1, AASSC_NEG_GROUND, 4'h0);
        $display("test reset values done");
        wr_reg(8'hdb, 16'hffff);
        rd_chk(8'hdb, 16'he01f);
        wr_reg(8'h00, 16'hffff);
        rd_chk(8'h00, 16'h0000);
        rd_chk(8'hdc, 16'h000c);
        $display("test reserved and unmapped done");
        // Every positive code, every gain code and both negative settings pass through the step port.
        for (i = 0; i < 16; i++) begin
            v = {1'b1, i[1:0], 8'h00, i[0], i[3:0]};
            eg = (i[1:0] == 2'h0) ? AASSC_GAIN_X1 : (i[1:0] == 2'h1) ? AASSC_GAIN_X2 : AASSC_GAIN_X4;
            en = (i >= 8) ? AASSC_NEG_AUTO : (i[0] ? AASSC_NEG_EXT7 : AASSC_NEG_GROUND);
            wr_reg(8'hdb, v);
            step_chk(4'hb, 1'b1, eg, en, i[3:0]);
        end
        wr_reg(8'hdc, 16'h8017);
        step_chk(4'hc, 1'b1, AASSC_GAIN_X1, AASSC_NEG_EXT7, 4'h7);
        $display("test step settings done");
        // A disabled or unknown step leaves the last applied settings in place.
        wr_reg(8'hdb, 16'h0005);
        step_chk(4'hb, 1'b0, AASSC_GAIN_X1, AASSC_NEG_EXT7, 4'h7);
        step_chk(4'h3, 1'b0, AASSC_GAIN_X1, AASSC_NEG_EXT7, 4'h7);
        rd_chk(8'hdb, 16'h0005);
        $display("test disabled steps done");
        // A reset in mid-run brings back the defaults and clears the applied settings.
        @(posedge clock);
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        rd_chk(8'hdb, 16'h000b);
        rd_chk(8'hdc, 16'h000c);
        step_chk(4'hb, 1'b0, AASSC_GAIN_X1, AASSC_NEG_GROUND, 4'h0);
        $display("test mid-run reset done");
        results();
    end
endmodule : aassc_step_cfg_tb
